//--- common/ttc_map.svh
// Register offsets, field positions, reset values and timing counts of the time tag control.
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TTC_CFG_OFS 5'h00
`define TTC_RT1_UTIL_OFS 5'h04
`define TTC_RT1_CNT_OFS 5'h08
`define TTC_RT2_CNT_OFS 5'h0C
`define TTC_BC_LO_OFS 5'h10
`define TTC_BC_HI_OFS 5'h14
`define TTC_MON_CNT_OFS 5'h18

// ----------------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------------
`define TTC_ACT_HI 9
`define TTC_ACT_LO 8
`define TTC_MON_HI 7
`define TTC_MON_LO 4
`define TTC_BC_WIDE_BIT 3
`define TTC_SH_HI 2
`define TTC_SH_LO 0
`define TTC_CFG_RST 16'h0000
`define TTC_ACT_NONE 2'h0
`define TTC_ACT_CLEAR 2'h1
`define TTC_ACT_LOAD 2'h2
`define TTC_SEL_OFF 4'h0
`define TTC_SEL_EXT 4'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TTC_CLK_NS 10
`define TTC_US_NS 1000
`define TTC_US_CYCLES (`TTC_US_NS / `TTC_CLK_NS)
`define TTC_LONG_TICK_US 7'h64

`endif

//--- common/ttc_pkg.sv
// Types shared by the time tag control modules.
`default_nettype none
package ttc_pkg;
  typedef enum logic [1:0] {
    TTC_BUS_IDLE = 2'b01,
    TTC_BUS_ACK = 2'b10
  } ttc_bus_state_t;
endpackage
`default_nettype wire

//--- core/ttc_tick_gen.sv
// Tick source: external pin edge or internal microsecond period.
`include "ttc_map.svh"
`default_nettype none
module ttc_tick_gen (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Selection
  input wire logic enable_in,
  input wire logic ext_sel_in,
  input wire logic [6:0] period_us_in,
  // External tick pin
  input wire logic ext_pin_in,
  // Tick
  output logic tick_out
);
  logic sync1_q, sync2_q, sync3_q;
  logic [6:0] pre_q, pre_d, us_q, us_d;
  logic tick_q, tick_d;
  logic us_stb, period_end;

  always_comb begin
    us_stb = (pre_q == 7'(`TTC_US_CYCLES - 1));
    period_end = us_stb && (us_q >= period_us_in - 7'h01);
    pre_d = us_stb ? 7'h00 : pre_q + 7'h01;
    us_d = us_q;
    if (us_stb) begin
      us_d = period_end ? 7'h00 : us_q + 7'h01;
    end
    if (!enable_in || ext_sel_in) begin
      pre_d = 7'h00;
      us_d = 7'h00;
    end
    tick_d = ext_sel_in ? (sync2_q && !sync3_q) : period_end;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      pre_q <= 7'h00;
      us_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      sync1_q <= ext_pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pre_q <= pre_d;
      us_q <= us_d;
      tick_q <= tick_d;
    end
  end

  // A disabled source gives no tick, even one already in flight.
  assign tick_out = tick_q & enable_in; // R09

  property p_ext_edge;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ext_sel_in && sync2_q && !sync3_q) |=> tick_q;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin edge gave no tick"); // R04
endmodule
`default_nettype wire

//--- core/ttc_top.sv
// Time tag counter control with Avalon-MM register slave.
// Operation
// R01: Action code 01 clears the RT1 counter; 00 and 11 do nothing.
// R02: Action code 10 loads the RT1 counter from the RT1 utility register.
// R03: The action field at bits 9-8 returns to 00 after acting.
// R04: Monitor select 0000 disables its counter; 0001 uses the monitor pin.
// R05: Monitor codes 0010-0111 tick 2 to 64 us; top bit set ticks 100 us.
// R06: Bit 3 makes the bus controller counter 16 bits at 0, 32 at 1.
// R07: Shared select bits 2-0: 000 disables, 001 uses the shared pin.
// R08: Shared codes 010-111 tick 2, 4, 8, 16, 32, 64 us.
// R09: Enabled counters count each tick and hold while disabled. RT1 drops a shared tick that meets a clear or load action.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`include "ttc_map.svh"
`default_nettype none
module ttc_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // External tick pins
  input wire logic monitor_ext_tick_pin_in,
  input wire logic shared_ext_tick_pin_in,
  // Counter values
  output logic [15:0] rt1_time_out,
  output logic [15:0] rt2_time_out,
  output logic [31:0] bc_time_out,
  output logic [15:0] mon_time_out
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] tick_period(input logic [3:0] code);
    tick_period = code[3] ? `TTC_LONG_TICK_US : (7'h01 << (code[2:0] - 3'h1));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  ttc_pkg::ttc_bus_state_t state_q, state_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] action_q, action_d;
  logic [3:0] mon_sel_q, mon_sel_d;
  logic bc_wide_q, bc_wide_d;
  logic [2:0] sh_sel_q, sh_sel_d;
  logic [15:0] rt1_util_q, rt1_util_d;
  logic [15:0] rt1_cnt_q, rt1_cnt_d, rt2_cnt_q, rt2_cnt_d, mon_cnt_q, mon_cnt_d;
  logic [31:0] bc_cnt_q, bc_cnt_d;
  logic [15:0] cfg_word, cfg_new, bc_lo_inc;
  logic [6:0] mon_period, sh_period;
  logic wr_go, mon_tick, sh_tick;
  localparam logic [15:0] CFG_RST = `TTC_CFG_RST;

  assign cfg_word = {6'h00, action_q, mon_sel_q, bc_wide_q, sh_sel_q};
  assign mon_period = tick_period(mon_sel_q); // R05
  assign sh_period = tick_period({1'b0, sh_sel_q}); // R08

  // ----------------------------------------------------------------------
  // Tick sources
  // ----------------------------------------------------------------------
  ttc_tick_gen u_mon_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(mon_sel_q != `TTC_SEL_OFF), // R04
    .ext_sel_in(mon_sel_q == `TTC_SEL_EXT), // R04
    .period_us_in(mon_period),
    .ext_pin_in(monitor_ext_tick_pin_in),
    .tick_out(mon_tick)
  );

  ttc_tick_gen u_sh_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(sh_sel_q != 3'h0), // R07
    .ext_sel_in(sh_sel_q == 3'h1), // R07
    .period_us_in(sh_period),
    .ext_pin_in(shared_ext_tick_pin_in),
    .tick_out(sh_tick)
  );

  // ----------------------------------------------------------------------
  // Bus slave and configuration
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    wr_go = 1'b0;
    cfg_new = merge16(cfg_word, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
    action_d = `TTC_ACT_NONE; // R03
    mon_sel_d = mon_sel_q;
    bc_wide_d = bc_wide_q;
    sh_sel_d = sh_sel_q;
    rt1_util_d = rt1_util_q;
    case (state_q)
      ttc_pkg::TTC_BUS_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          state_d = ttc_pkg::TTC_BUS_ACK;
          wait_d = 1'b0;
          rdata_d = 32'h0000_0000;
          if (avs_read_in) begin
            case (avs_address_in)
              `TTC_CFG_OFS: rdata_d = {16'h0000, cfg_word};
              `TTC_RT1_UTIL_OFS: rdata_d = {16'h0000, rt1_util_q};
              `TTC_RT1_CNT_OFS: rdata_d = {16'h0000, rt1_cnt_q};
              `TTC_RT2_CNT_OFS: rdata_d = {16'h0000, rt2_cnt_q};
              `TTC_BC_LO_OFS: rdata_d = {16'h0000, bc_cnt_q[15:0]};
              `TTC_BC_HI_OFS: rdata_d = {16'h0000, bc_cnt_q[31:16]};
              `TTC_MON_CNT_OFS: rdata_d = {16'h0000, mon_cnt_q};
              default: rdata_d = 32'h0000_0000;
            endcase
          end
        end
      end
      ttc_pkg::TTC_BUS_ACK: begin
        state_d = ttc_pkg::TTC_BUS_IDLE;
        wr_go = avs_write_in;
      end
      default: state_d = ttc_pkg::TTC_BUS_IDLE;
    endcase
    if (wr_go && avs_address_in == `TTC_CFG_OFS) begin
      action_d = cfg_new[`TTC_ACT_HI:`TTC_ACT_LO];
      mon_sel_d = cfg_new[`TTC_MON_HI:`TTC_MON_LO];
      bc_wide_d = cfg_new[`TTC_BC_WIDE_BIT];
      sh_sel_d = cfg_new[`TTC_SH_HI:`TTC_SH_LO];
    end
    if (wr_go && avs_address_in == `TTC_RT1_UTIL_OFS) begin
      rt1_util_d = merge16(rt1_util_q, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ttc_pkg::TTC_BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      action_q <= `TTC_ACT_NONE;
      mon_sel_q <= CFG_RST[`TTC_MON_HI:`TTC_MON_LO];
      bc_wide_q <= CFG_RST[`TTC_BC_WIDE_BIT];
      sh_sel_q <= CFG_RST[`TTC_SH_HI:`TTC_SH_LO];
      rt1_util_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      action_q <= action_d;
      mon_sel_q <= mon_sel_d;
      bc_wide_q <= bc_wide_d;
      sh_sel_q <= sh_sel_d;
      rt1_util_q <= rt1_util_d;
    end
  end

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  always_comb begin
    rt1_cnt_d = rt1_cnt_q;
    rt2_cnt_d = rt2_cnt_q;
    bc_cnt_d = bc_cnt_q;
    mon_cnt_d = mon_cnt_q;
    bc_lo_inc = bc_cnt_q[15:0] + 16'h0001;
    if (action_q == `TTC_ACT_CLEAR) begin
      rt1_cnt_d = 16'h0000; // R01
    end else if (action_q == `TTC_ACT_LOAD) begin
      rt1_cnt_d = rt1_util_q; // R02
    end else if (sh_tick) begin
      rt1_cnt_d = rt1_cnt_q + 16'h0001; // R09
    end
    if (sh_tick) begin
      rt2_cnt_d = rt2_cnt_q + 16'h0001; // R09
      if (bc_wide_q) begin
        bc_cnt_d = bc_cnt_q + 32'h0000_0001; // R06
      end else begin
        bc_cnt_d = {16'h0000, bc_lo_inc}; // R06
      end
    end
    if (mon_tick) begin
      mon_cnt_d = mon_cnt_q + 16'h0001; // R09
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rt1_cnt_q <= 16'h0000;
      rt2_cnt_q <= 16'h0000;
      bc_cnt_q <= 32'h0000_0000;
      mon_cnt_q <= 16'h0000;
    end else begin
      rt1_cnt_q <= rt1_cnt_d;
      rt2_cnt_q <= rt2_cnt_d;
      bc_cnt_q <= bc_cnt_d;
      mon_cnt_q <= mon_cnt_d;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign rt1_time_out = rt1_cnt_q;
  assign rt2_time_out = rt2_cnt_q;
  assign bc_time_out = bc_cnt_q;
  assign mon_time_out = mon_cnt_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_cfg_write(logic [1:0] code);
    wr_go && avs_address_in == `TTC_CFG_OFS && cfg_new[`TTC_ACT_HI:`TTC_ACT_LO] == code;
  endsequence

  property p_act_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_cfg_write(`TTC_ACT_CLEAR) |=> ##1 (rt1_cnt_q == 16'h0000);
  endproperty
  a_act_clear: assert property (p_act_clear) else $error("clear action missed"); // R01

  property p_act_load;
    @(posedge clk_in) disable iff (sys_rst_in)
      (action_q == `TTC_ACT_LOAD) |=> (rt1_cnt_q == $past(rt1_util_q));
  endproperty
  a_act_load: assert property (p_act_load) else $error("load action missed"); // R02

  property p_act_self;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_cfg_write(`TTC_ACT_LOAD) |=> (action_q == `TTC_ACT_LOAD) ##1 (action_q == `TTC_ACT_NONE);
  endproperty
  a_act_self: assert property (p_act_self) else $error("action field not self cleared"); // R03

  property p_mon_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
      (mon_sel_q == `TTC_SEL_OFF) |=> $stable(mon_cnt_q);
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("disabled monitor counter moved"); // R04

  property p_mon_period;
    @(posedge clk_in) disable iff (sys_rst_in)
      (mon_sel_q[3] |-> mon_period == 7'h64) and
      (mon_sel_q == 4'h2 |-> mon_period == 7'h02) and
      (mon_sel_q == 4'h7 |-> mon_period == 7'h40);
  endproperty
  a_mon_period: assert property (p_mon_period) else $error("monitor period wrong"); // R05

  property p_bc_width;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sh_tick && bc_cnt_q[15:0] == 16'hFFFF) |=>
        (bc_cnt_q[31:16] == ($past(bc_wide_q) ? $past(bc_cnt_q[31:16]) + 16'h0001 : 16'h0000));
  endproperty
  a_bc_width: assert property (p_bc_width) else $error("bus controller width wrong"); // R06

  property p_bc_narrow;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sh_tick && !bc_wide_q) |=> (bc_cnt_q[31:16] == 16'h0000);
  endproperty
  a_bc_narrow: assert property (p_bc_narrow) else $error("bc upper half not cleared"); // R06

  property p_sh_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sh_sel_q == 3'h0) |=> $stable(rt2_cnt_q) && $stable(bc_cnt_q);
  endproperty
  a_sh_hold: assert property (p_sh_hold) else $error("disabled shared counters moved"); // R07

  property p_sh_period;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sh_sel_q == 3'h3 |-> sh_period == 7'h04) and
      (sh_sel_q == 3'h7 |-> sh_period == 7'h40);
  endproperty
  a_sh_period: assert property (p_sh_period) else $error("shared period wrong"); // R08

  property p_inc;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sh_tick && action_q == `TTC_ACT_NONE) |=>
        (rt1_cnt_q == $past(rt1_cnt_q) + 16'h0001) && (rt2_cnt_q == $past(rt2_cnt_q) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("counter missed a tick"); // R09
endmodule
`default_nettype wire

//--- dv/ttc_top_test.sv
// Self-checking testbench of the time tag counter control.
`include "ttc_map.svh"
`default_nettype none
module ttc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic monitor_ext_tick_pin_in = 1'b0;
  logic shared_ext_tick_pin_in = 1'b0;
  logic [15:0] rt1_time_out;
  logic [15:0] rt2_time_out;
  logic [31:0] bc_time_out;
  logic [15:0] mon_time_out;
  int n_errors = 0;
  int compares = 0;

  ttc_top i_ttc_top (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .monitor_ext_tick_pin_in(monitor_ext_tick_pin_in),
    .shared_ext_tick_pin_in(shared_ext_tick_pin_in),
    .rt1_time_out(rt1_time_out), .rt2_time_out(rt2_time_out),
    .bc_time_out(bc_time_out), .mon_time_out(mon_time_out)
  );

  always #5 clk_in = ~clk_in;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string m);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, exp, m);
  endtask

  task automatic pulse(input int n, input logic mon, input logic sh);
    repeat (n) begin
      @(posedge clk_in);
      monitor_ext_tick_pin_in <= mon;
      shared_ext_tick_pin_in <= sh;
      repeat (4) @(posedge clk_in);
      monitor_ext_tick_pin_in <= 1'b0;
      shared_ext_tick_pin_in <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    repeat (8) @(posedge clk_in);
  endtask

  task automatic period_chk(input bit mon, input int exp);
    logic [15:0] v;
    int n;
    v = mon ? mon_time_out : rt2_time_out;
    n = 0;
    while ((mon ? mon_time_out : rt2_time_out) === v && n < 20000) begin
      @(posedge clk_in);
      n++;
    end
    v = mon ? mon_time_out : rt2_time_out;
    n = 0;
    while ((mon ? mon_time_out : rt2_time_out) === v && n < 20000) begin
      @(posedge clk_in);
      n++;
    end
    chk(n, exp, "tick period");
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd(`TTC_CFG_OFS, 32'h0000_0000, "cfg reset");
    chk({16'h0000, rt1_time_out}, 32'h0000_0000, "rt1 reset");
    wr(`TTC_CFG_OFS, 16'h0008);
    rd(`TTC_CFG_OFS, 32'h0000_0008, "wide bit");
    chk({16'h0000, bc_time_out[31:16]}, 32'h0000_0000, "bc upper");
    wr(`TTC_CFG_OFS, 16'h0000);
    rd(5'h1C, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_action();
    wr(`TTC_RT1_UTIL_OFS, 16'hA5C3);
    wr(`TTC_CFG_OFS, 16'h0200);
    repeat (2) @(posedge clk_in);
    chk({16'h0000, rt1_time_out}, 32'h0000_A5C3, "load");
    rd(`TTC_CFG_OFS, 32'h0000_0000, "action self clear");
    rd(`TTC_RT1_CNT_OFS, 32'h0000_A5C3, "load reg");
    wr(`TTC_CFG_OFS, 16'h0300);
    repeat (2) @(posedge clk_in);
    chk({16'h0000, rt1_time_out}, 32'h0000_A5C3, "code 11");
    rd(`TTC_CFG_OFS, 32'h0000_0000, "code 11 self clear");
    wr(`TTC_CFG_OFS, 16'h0100);
    repeat (2) @(posedge clk_in);
    chk({16'h0000, rt1_time_out}, 32'h0000_0000, "clear");
    rd(`TTC_CFG_OFS, 32'h0000_0000, "clear self clear");
    $display("test action done");
  endtask

  task automatic t_pins();
    wr(`TTC_CFG_OFS, 16'h0011);
    pulse(5, 1'b1, 1'b1);
    chk({16'h0000, rt1_time_out}, 32'h0000_0005, "rt1 pin");
    chk({16'h0000, rt2_time_out}, 32'h0000_0005, "rt2 pin");
    chk(bc_time_out, 32'h0000_0005, "bc pin");
    chk({16'h0000, mon_time_out}, 32'h0000_0005, "mon pin");
    pulse(2, 1'b1, 1'b0);
    chk({16'h0000, mon_time_out}, 32'h0000_0007, "mon pin only");
    chk({16'h0000, rt2_time_out}, 32'h0000_0005, "shared pin idle");
    wr(`TTC_CFG_OFS, 16'h0000);
    pulse(3, 1'b1, 1'b1);
    rd(`TTC_RT1_CNT_OFS, 32'h0000_0005, "rt1 hold");
    rd(`TTC_BC_LO_OFS, 32'h0000_0005, "bc hold");
    rd(`TTC_BC_HI_OFS, 32'h0000_0000, "bc hi");
    rd(`TTC_MON_CNT_OFS, 32'h0000_0007, "mon hold");
    $display("test pins done");
  endtask

  task automatic t_shared();
    for (int s = 2; s < 8; s++) begin
      wr(`TTC_CFG_OFS, 16'(s));
      period_chk(1'b0, (2 << (s - 2)) * `TTC_US_CYCLES);
    end
    wr(`TTC_CFG_OFS, 16'h0000);
    $display("test shared done");
  endtask

  task automatic t_monitor();
    for (int m = 2; m < 9; m++) begin
      wr(`TTC_CFG_OFS, 16'(m << 4));
      period_chk(1'b1, (m == 8 ? 100 : (2 << (m - 2))) * `TTC_US_CYCLES);
    end
    wr(`TTC_CFG_OFS, 16'h0000);
    $display("test monitor done");
  endtask

  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_action();
    t_pins();
    t_shared();
    t_monitor();
    stop_test();
  end

  initial begin
    #1000000;
    n_errors++;
    $display("BAD %0t watchdog", $time);
    stop_test();
  end
endmodule
`default_nettype wire
